// [hw/cpm_consts.svh]
// register offsets, field positions, reset values and timing of the control port
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

// ==========================================================================
// register map, page 0 unless noted
`define CPM_PAGE_REGS       128
`define CPM_PAGE_SEL_OFS    7'h00
`define CPM_SOFT_RST_OFS    7'h01
`define CPM_SLEEP_CFG_OFS   7'h02
`define CPM_INPUT_CHANNEL_ENABLES_OFS    7'h73
`define CPM_OUT_SLOT_OFS    7'h74
`define CPM_POWER_UP_CONFIG_OFS     7'h75
`define CPM_STS_A_OFS       7'h76
`define CPM_STS_B_OFS       7'h77

// ==========================================================================
// field positions
`define CPM_SLEEP_EXIT_BIT  0
`define CPM_BCAST_EN_BIT    2
`define CPM_SOFT_RST_BIT    0
`define CPM_PWR_ANALOG_BIT  7
`define CPM_PWR_DIGITAL_BIT 6

// ==========================================================================
// pages and reset values
`define CPM_CFG_PAGE        8'h00
`define CPM_STS_PAGE        8'h01
`define CPM_COEF_FIRST      8'h02
`define CPM_PAGE_RESET      8'h00
`define CPM_REG_RESET       8'h00

// ==========================================================================
// i2c addressing
`define CPM_ADDR_FIXED      5'h12
`define CPM_BCAST_ADDR      7'h48

// ==========================================================================
// timing
`define CPM_SYS_CLK_MHZ     50
`define CPM_WAKE_TIME_US    1000
`define CPM_RAMP_CYCLES     256

`endif

// [hw/cpm_pkg.sv]
// types shared by the control port modules
package cpm_pkg;
	typedef enum logic [1:0] {
		PW_SLEEP,
		PW_WAKE,
		PW_ACTIVE,
		PW_RAMP
	} cpm_power_t;

	typedef enum logic [3:0] {
		LK_IDLE,
		LK_ADDR,
		LK_ADDR_ACK,
		LK_REG,
		LK_REG_ACK,
		LK_WDATA,
		LK_WDATA_ACK,
		LK_FETCH,
		LK_RDATA,
		LK_RACK,
		LK_RNEXT
	} cpm_link_t;
endpackage

// [hw/cpm_reg_if.sv]
// register access path between the link crossing and the register bank
`timescale 1ns/1ps
interface cpm_reg_if;
	logic       we;
	logic       re;
	logic [6:0] offset;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] page;
	logic       sleep_exit;
	logic       bcast_en;
	logic [7:0] input_channel_enables;
	logic [7:0] out_slot_en;
	logic [7:0] power_up_config;
	logic       soft_rst;
	logic [7:0] sts_a;
	logic [7:0] sts_b;
	logic [7:0] live_data;

	modport bank (
		input  we, re, offset, wdata, sts_a, sts_b, live_data,
		output rdata, page, sleep_exit, bcast_en, input_channel_enables, out_slot_en,
		       power_up_config, soft_rst
	);
	modport host (
		output we, re, offset, wdata, sts_a, sts_b, live_data,
		input  rdata, page, sleep_exit, bcast_en, input_channel_enables, out_slot_en,
		       power_up_config, soft_rst
	);
endinterface

// [hw/cpm_reg_bank.sv]
// paged 8-bit register bank: configuration page and coefficient pages
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_reg_bank #(
	parameter int COEF_PAGES = 3
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst,     // async reset, active high
	cpm_reg_if.bank  bus        // register access
);
	localparam int NBANK = COEF_PAGES + 1;

	generate
		if (COEF_PAGES < 1 || COEF_PAGES > 3) begin : g_chk
			$error("COEF_PAGES must be 1 to 3");
		end
	endgenerate

	// ======================================================================
	// decode
	// bit 2 marks a stored page, bits 1:0 its bank
	function automatic logic [2:0] bank_of(input logic [7:0] pg);
		if (pg == `CPM_CFG_PAGE)
			bank_of = 3'h4;
		else if (pg >= `CPM_COEF_FIRST
			&& int'(pg) < int'(`CPM_COEF_FIRST) + COEF_PAGES)
			bank_of = {1'b1, 2'(int'(pg) - int'(`CPM_COEF_FIRST) + 1)};
		else
			bank_of = 3'h0;
	endfunction

	// page 0 locations that hold no stored value
	function automatic logic is_volatile(input logic [6:0] ofs);
		is_volatile = (ofs == `CPM_SOFT_RST_OFS) || (ofs == `CPM_STS_A_OFS)
			|| (ofs == `CPM_STS_B_OFS);
	endfunction

	logic [7:0] mem [0:NBANK*`CPM_PAGE_REGS-1];
	logic [7:0] page;
	logic [2:0] wsel;
	logic [8:0] widx;
	logic       wr_store;

	assign wsel     = bank_of(page);
	assign widx     = {wsel[1:0], bus.offset};
	assign wr_store = bus.we && wsel[2] && bus.offset != `CPM_PAGE_SEL_OFS
		&& !(wsel[1:0] == 2'h0 && is_volatile(bus.offset));

	// ======================================================================
	// storage; sleep never clears it, only reset and soft restore do
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < NBANK*`CPM_PAGE_REGS; i++)
				mem[i] <= `CPM_REG_RESET;
		end else if (bus.soft_rst) begin
			for (int i = 0; i < NBANK*`CPM_PAGE_REGS; i++)
				mem[i] <= `CPM_REG_RESET;
		end else if (wr_store) begin
			mem[widx] <= bus.wdata;
		end
	end

	// offset 0 of every page switches the page
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			page <= `CPM_PAGE_RESET;
		else if (bus.soft_rst)
			page <= `CPM_PAGE_RESET;
		else if (bus.we && bus.offset == `CPM_PAGE_SEL_OFS)
			page <= bus.wdata;
	end

	// self-clearing: one pulse, the bit itself is never stored
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			bus.soft_rst <= 1'b0;
		else
			bus.soft_rst <= bus.we && page == `CPM_CFG_PAGE
				&& bus.offset == `CPM_SOFT_RST_OFS
				&& bus.wdata[`CPM_SOFT_RST_BIT];
	end

	// ======================================================================
	// read path
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			bus.rdata <= 8'h00;
		end else if (bus.re) begin
			if (bus.offset == `CPM_PAGE_SEL_OFS)
				bus.rdata <= page;
			else if (page == `CPM_STS_PAGE)
				bus.rdata <= bus.live_data;
			else if (page == `CPM_CFG_PAGE && is_volatile(bus.offset))
				bus.rdata <= (bus.offset == `CPM_STS_A_OFS) ? bus.sts_a
					: (bus.offset == `CPM_STS_B_OFS) ? bus.sts_b : 8'h00;
			else if (bank_of(page) != 3'h0)
				bus.rdata <= mem[{wsel[1:0], bus.offset}];
			else
				bus.rdata <= 8'h00;
		end
	end

	assign bus.sleep_exit  = mem[`CPM_SLEEP_CFG_OFS][`CPM_SLEEP_EXIT_BIT];
	assign bus.bcast_en    = mem[`CPM_SLEEP_CFG_OFS][`CPM_BCAST_EN_BIT];
	assign bus.input_channel_enables    = mem[`CPM_INPUT_CHANNEL_ENABLES_OFS];
	assign bus.out_slot_en = mem[`CPM_OUT_SLOT_OFS];
	assign bus.power_up_config     = mem[`CPM_POWER_UP_CONFIG_OFS];
	assign bus.page        = page;
endmodule // cpm_reg_bank

// [hw/cpm_power_seq.sv]
// sleep, wake-up, active and ramp-down sequencing
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_power_seq #(
	parameter int WAKE_CYCLES = `CPM_WAKE_TIME_US * `CPM_SYS_CLK_MHZ,
	parameter int RAMP_CYCLES = `CPM_RAMP_CYCLES
) (
	input  wire logic       i_sys_clk,    // system clock
	input  wire logic       i_rst,        // async reset, active high
	input  wire logic       i_sleep_exit, // low_power_exit_bit
	input  wire logic       i_force_off,  // soft restore pulse
	input  wire logic [7:0] i_power_up_config,    // power_up_config
	output logic            o_ramp_down,  // volume ramping down
	output logic            o_analog_en,  // analog blocks powered
	output logic            o_digital_en, // digital blocks powered
	output logic            o_sleeping,   // in sleep
	output logic            o_active      // active, accepts setup
);
	localparam int CMAX = (WAKE_CYCLES > RAMP_CYCLES) ? WAKE_CYCLES : RAMP_CYCLES;
	localparam int CW   = $clog2(CMAX + 1);

	generate
		if (WAKE_CYCLES < 1 || RAMP_CYCLES < 1) begin : g_chk
			$error("cycle counts must be at least one");
		end
	endgenerate

	cpm_pkg::cpm_power_t state;
	logic [CW-1:0]       cnt;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= cpm_pkg::PW_SLEEP;
			cnt   <= '0;
		end else if (i_force_off) begin
			state <= cpm_pkg::PW_SLEEP;
			cnt   <= '0;
		end else begin
			unique case (state)
				cpm_pkg::PW_SLEEP: begin
					if (i_sleep_exit) begin
						state <= cpm_pkg::PW_WAKE;
						cnt   <= CW'(WAKE_CYCLES - 1);
					end
				end
				cpm_pkg::PW_WAKE: begin
					if (!i_sleep_exit)
						state <= cpm_pkg::PW_SLEEP;
					else if (cnt == '0)
						state <= cpm_pkg::PW_ACTIVE;
					else
						cnt <= cnt - 1'b1;
				end
				cpm_pkg::PW_ACTIVE: begin
					if (!i_sleep_exit) begin
						state <= cpm_pkg::PW_RAMP;
						cnt   <= CW'(RAMP_CYCLES - 1);
					end
				end
				cpm_pkg::PW_RAMP: begin
					if (cnt == '0)
						state <= cpm_pkg::PW_SLEEP;
					else
						cnt <= cnt - 1'b1;
				end
			endcase
		end
	end

	// digital stays up through the ramp so the volume can fall smoothly
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ramp_down  <= 1'b0;
			o_analog_en  <= 1'b0;
			o_digital_en <= 1'b0;
			o_sleeping   <= 1'b1;
			o_active     <= 1'b0;
		end else begin
			o_ramp_down  <= state == cpm_pkg::PW_RAMP;
			o_analog_en  <= (state == cpm_pkg::PW_ACTIVE
				|| state == cpm_pkg::PW_RAMP) && i_power_up_config[`CPM_PWR_ANALOG_BIT];
			o_digital_en <= (state == cpm_pkg::PW_ACTIVE
				|| state == cpm_pkg::PW_RAMP) && i_power_up_config[`CPM_PWR_DIGITAL_BIT];
			o_sleeping   <= state == cpm_pkg::PW_SLEEP;
			o_active     <= state == cpm_pkg::PW_ACTIVE;
		end
	end
endmodule // cpm_power_seq

// [hw/cpm_ctrl_port.sv]
// control port top: i2c slave on the link clock, registers, power modes
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_ctrl_port #(
	parameter int WAKE_CYCLES = `CPM_WAKE_TIME_US * `CPM_SYS_CLK_MHZ,
	parameter int RAMP_CYCLES = `CPM_RAMP_CYCLES,
	parameter int COEF_PAGES  = 3
) (
	input  wire logic       i_sys_clk,                       // 50 MHz
	input  wire logic       i_rst,                           // async, high
	input  wire logic       i_link_clk,                      // pin sampling
	input  wire logic       i_data_or_select_pin,            // sda level
	output logic            o_data_or_select_pin,            // sda drive
	output logic            o_data_or_select_pin_oe,         // pull sda low
	input  wire logic       i_scl_or_host_out_pin,           // scl level
	output logic            o_scl_or_host_out_pin,           // scl drive
	output logic            o_scl_or_host_out_pin_oe,        // stretch scl
	input  wire logic       i_addr_bit0_or_serial_clock_pin, // addr bit 0
	input  wire logic       i_addr_bit1_or_host_in_pin,      // addr bit 1
	input  wire logic [7:0] i_live_data,                     // page 1 data
	output logic      [7:0] o_input_channel_enables,         // register
	output logic      [7:0] o_output_slot_enables,           // register
	output logic            o_ramp_down,                     // volume ramp
	output logic            o_analog_power_en,               // analog on
	output logic            o_digital_power_en,              // digital on
	output logic            o_sleeping,                      // sleep mode
	output logic            o_soft_restore,                  // restore pulse
	output logic            o_i2c_selected,                  // i2c in use
	output logic            o_spi_selected                   // spi in use
);
	cpm_reg_if regs ();

	// ======================================================================
	// link reset and pin synchronisers
	logic [1:0] lrst_q;
	logic       link_rst;

	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst)
			lrst_q <= 2'h3;
		else
			lrst_q <= {lrst_q[0], 1'b0};
	end
	assign link_rst = lrst_q[1];

	// bits: 0 scl, 1 sda, 2 addr0, 3 addr1, 4 broadcast enable, 5 ack
	logic [5:0] pin_raw;
	logic [5:0] pin_q1;
	logic [5:0] pin_s;
	logic       req_tgl;
	logic       ack_tgl;

	assign pin_raw = {ack_tgl, regs.bcast_en, i_addr_bit1_or_host_in_pin,
		i_addr_bit0_or_serial_clock_pin, i_data_or_select_pin,
		i_scl_or_host_out_pin};

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_sync
			always_ff @(posedge i_link_clk or posedge link_rst) begin
				if (link_rst) begin
					pin_q1[g] <= (g < 2) ? 1'b1 : 1'b0;
					pin_s[g]  <= (g < 2) ? 1'b1 : 1'b0;
				end else begin
					pin_q1[g] <= pin_raw[g];
					pin_s[g]  <= pin_q1[g];
				end
			end
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;

	assign scl_s = pin_s[0];
	assign sda_s = pin_s[1];

	always_ff @(posedge i_link_clk or posedge link_rst) begin
		if (link_rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic sda_fall;
	logic start_c;
	logic stop_c;

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign sda_fall = !sda_s && sda_d;
	assign start_c  = scl_s && scl_d && sda_fall;
	assign stop_c   = scl_s && scl_d && sda_s && !sda_d;

	// ======================================================================
	// interface detection: first select/data fall decides, then locks
	logic i2c_sel;
	logic spi_sel;

	always_ff @(posedge i_link_clk or posedge link_rst) begin
		if (link_rst) begin
			i2c_sel <= 1'b0;
			spi_sel <= 1'b0;
		end else if (!i2c_sel && !spi_sel && sda_fall) begin
			i2c_sel <= scl_s;
			spi_sel <= !scl_s;
		end
	end

	// ======================================================================
	// slave address
	logic [6:0] slave_addr;

	assign slave_addr = pin_s[4] ? `CPM_BCAST_ADDR
		: {`CPM_ADDR_FIXED, pin_s[3], pin_s[2]};

	// ======================================================================
	// i2c byte engine; sampling at link rate covers all three bus speeds
	cpm_pkg::cpm_link_t state;
	logic [3:0]         cnt;
	logic [7:0]         shreg;
	logic               rw;
	logic [7:0]         ptr;
	logic               sda_oe;
	logic               scl_oe;
	logic               req_wr;
	logic [7:0]         req_ptr;
	logic [7:0]         req_data;
	logic               fetch_done;

	assign fetch_done = pin_s[5] == req_tgl;

	always_ff @(posedge i_link_clk or posedge link_rst) begin
		if (link_rst) begin
			state    <= cpm_pkg::LK_IDLE;
			cnt      <= 4'h0;
			shreg    <= 8'h00;
			rw       <= 1'b0;
			ptr      <= 8'h00;
			sda_oe   <= 1'b0;
			scl_oe   <= 1'b0;
			req_tgl  <= 1'b0;
			req_wr   <= 1'b0;
			req_ptr  <= 8'h00;
			req_data <= 8'h00;
		// the start that decides the interface is a frame too, not lost
		end else if (!(i2c_sel || (!spi_sel && start_c))) begin
			state  <= cpm_pkg::LK_IDLE;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (start_c) begin
			state  <= cpm_pkg::LK_ADDR;
			cnt    <= 4'h0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (stop_c) begin
			state  <= cpm_pkg::LK_IDLE;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			unique case (state)
				cpm_pkg::LK_IDLE: ;
				cpm_pkg::LK_ADDR, cpm_pkg::LK_REG, cpm_pkg::LK_WDATA: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						cnt   <= cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						cnt <= 4'h0;
						if (state == cpm_pkg::LK_ADDR) begin
							if (shreg[7:1] == slave_addr) begin
								rw     <= shreg[0];
								sda_oe <= 1'b1;
								state  <= cpm_pkg::LK_ADDR_ACK;
							end else begin
								state <= cpm_pkg::LK_IDLE;
							end
						end else if (state == cpm_pkg::LK_REG) begin
							ptr    <= shreg;
							sda_oe <= 1'b1;
							state  <= cpm_pkg::LK_REG_ACK;
						end else begin
							req_wr   <= 1'b1;
							req_ptr  <= ptr;
							req_data <= shreg;
							req_tgl  <= !req_tgl;
							ptr      <= ptr + 8'h01;
							sda_oe   <= 1'b1;
							state    <= cpm_pkg::LK_WDATA_ACK;
						end
					end
				end
				cpm_pkg::LK_ADDR_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						if (rw) begin
							req_wr  <= 1'b0;
							req_ptr <= ptr;
							req_tgl <= !req_tgl;
							scl_oe  <= 1'b1;
							state   <= cpm_pkg::LK_FETCH;
						end else begin
							state <= cpm_pkg::LK_REG;
						end
					end
				end
				cpm_pkg::LK_REG_ACK, cpm_pkg::LK_WDATA_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						state  <= cpm_pkg::LK_WDATA;
					end
				end
				// scl is held low until the word has crossed back
				cpm_pkg::LK_FETCH: begin
					if (fetch_done) begin
						shreg  <= regs.rdata;
						sda_oe <= !regs.rdata[7];
						scl_oe <= 1'b0;
						cnt    <= 4'h0;
						state  <= cpm_pkg::LK_RDATA;
					end
				end
				cpm_pkg::LK_RDATA: begin
					if (scl_fall) begin
						if (cnt == 4'h7) begin
							sda_oe <= 1'b0;
							state  <= cpm_pkg::LK_RACK;
						end else begin
							sda_oe <= !shreg[6];
							shreg  <= {shreg[6:0], 1'b0};
							cnt    <= cnt + 4'h1;
						end
					end
				end
				cpm_pkg::LK_RACK: begin
					if (scl_rise)
						state <= sda_s ? cpm_pkg::LK_IDLE
							: cpm_pkg::LK_RNEXT;
				end
				cpm_pkg::LK_RNEXT: begin
					if (scl_fall) begin
						ptr     <= ptr + 8'h01;
						req_wr  <= 1'b0;
						req_ptr <= ptr + 8'h01;
						req_tgl <= !req_tgl;
						scl_oe  <= 1'b1;
						state   <= cpm_pkg::LK_FETCH;
					end
				end
			endcase
		end
	end

	assign o_data_or_select_pin     = 1'b0;
	assign o_data_or_select_pin_oe  = sda_oe;
	assign o_scl_or_host_out_pin    = 1'b0;
	assign o_scl_or_host_out_pin_oe = scl_oe;

	// ======================================================================
	// request crossing into the system domain, toggle handshake;
	// word fields stay still from toggle until the ack returns
	logic [1:0] req_q;
	logic [1:0] mode_q1;
	logic [1:0] mode_q2;
	logic       req_edge;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			req_q   <= 2'h0;
			ack_tgl <= 1'b0;
			mode_q1 <= 2'h0;
			mode_q2 <= 2'h0;
		end else begin
			req_q   <= {req_q[0], req_tgl};
			ack_tgl <= req_q[1];
			mode_q1 <= {spi_sel, i2c_sel};
			mode_q2 <= mode_q1;
		end
	end

	assign req_edge     = req_q[1] ^ ack_tgl;
	assign regs.we      = req_edge && req_wr;
	assign regs.re      = req_edge && !req_wr;
	assign regs.offset  = req_ptr[6:0];
	assign regs.wdata   = req_data;
	assign regs.live_data = i_live_data;

	// ======================================================================
	// register bank and power sequencer
	cpm_reg_bank #(
		.COEF_PAGES (COEF_PAGES)
	) u_bank (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.bus       (regs.bank)
	);

	logic active;

	cpm_power_seq #(
		.WAKE_CYCLES (WAKE_CYCLES),
		.RAMP_CYCLES (RAMP_CYCLES)
	) u_power (
		.i_sys_clk    (i_sys_clk),
		.i_rst        (i_rst),
		.i_sleep_exit (regs.sleep_exit),
		.i_force_off  (regs.soft_rst),
		.i_power_up_config    (regs.power_up_config),
		.o_ramp_down  (o_ramp_down),
		.o_analog_en  (o_analog_power_en),
		.o_digital_en (o_digital_power_en),
		.o_sleeping   (o_sleeping),
		.o_active     (active)
	);

	assign regs.sts_a = {o_analog_power_en, o_digital_power_en, o_ramp_down,
		5'h00};
	assign regs.sts_b = {o_sleeping, active, 6'h00};

	assign o_input_channel_enables = regs.input_channel_enables;
	assign o_output_slot_enables   = regs.out_slot_en;
	assign o_soft_restore          = regs.soft_rst;
	assign o_i2c_selected          = mode_q2[0];
	assign o_spi_selected          = mode_q2[1];
endmodule // cpm_ctrl_port

// [sim/cpm_ctrl_port_assertions.sv]
// assertion checker bound to the control port top
`timescale 1ns/1ps
module cpm_ctrl_port_checker #(
	parameter int WAKE_CYCLES = 20, // wake span
	parameter int RAMP_CYCLES = 8,  // ramp span
	parameter int COEF_PAGES  = 3   // coefficient pages
) (
	input wire logic       i_sys_clk,               // sys clock
	input wire logic       i_rst,                   // reset
	input wire logic       i_link_clk,              // link clock
	input wire logic       i_scl_or_host_out_pin,   // scl wire
	input wire logic       o_data_or_select_pin_oe, // sda pull
	input wire logic [7:0] o_input_channel_enables, // channels
	input wire logic       o_ramp_down,             // ramp
	input wire logic       o_analog_power_en,       // analog
	input wire logic       o_digital_power_en,      // digital
	input wire logic       o_sleeping,              // sleep
	input wire logic       o_soft_restore,          // restore
	input wire logic       o_i2c_selected,          // i2c
	input wire logic       o_spi_selected           // spi
);
	// ========
	// power modes and interface lock
	property p_rst_pulse; @(posedge i_sys_clk) disable iff (i_rst)
		o_soft_restore |=> !o_soft_restore; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("long pulse");
	property p_rst_clear; @(posedge i_sys_clk) disable iff (i_rst)
		o_soft_restore |-> ##[0:3] (o_input_channel_enables == 8'h00); endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("not cleared");
	property p_rst_off; @(posedge i_sys_clk) disable iff (i_rst)
		o_soft_restore |-> ##[0:3] (o_sleeping && !o_analog_power_en); endproperty
	a_rst_off: assert property (p_rst_off) else $error("not shut down");
	property p_ramp_sleep; @(posedge i_sys_clk) disable iff (i_rst)
		$fell(o_ramp_down) |-> ##[0:2] o_sleeping; endproperty
	a_ramp_sleep: assert property (p_ramp_sleep) else $error("no sleep");
	property p_ramp_awake; @(posedge i_sys_clk) disable iff (i_rst)
		o_ramp_down |-> !o_sleeping; endproperty
	a_ramp_awake: assert property (p_ramp_awake) else $error("in sleep");
	property p_sleep_off; @(posedge i_sys_clk) disable iff (i_rst)
		o_sleeping |-> !(o_analog_power_en || o_digital_power_en); endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("powered");
	property p_iface_lock; @(posedge i_sys_clk) disable iff (i_rst)
		o_i2c_selected |=> o_i2c_selected && !o_spi_selected; endproperty
	a_iface_lock: assert property (p_iface_lock) else $error("moved");
	// ========
	// link: sda may only move while scl is low
	property p_ack_hold; @(posedge i_link_clk) disable iff (i_rst)
		i_scl_or_host_out_pin && $past(i_scl_or_host_out_pin)
		|-> $stable(o_data_or_select_pin_oe); endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda moved");
	c_restore: cover property (@(posedge i_sys_clk) o_soft_restore);
	c_ramp: cover property (@(posedge i_sys_clk) $fell(o_ramp_down));
	c_ack: cover property (@(posedge i_link_clk) $rose(o_data_or_select_pin_oe));
endmodule // cpm_ctrl_port_checker
bind cpm_ctrl_port cpm_ctrl_port_checker #(.WAKE_CYCLES(WAKE_CYCLES),
	.RAMP_CYCLES(RAMP_CYCLES), .COEF_PAGES(COEF_PAGES)) u_chk (.*);

// [sim/cpm_host_model.sv]
// i2c bus master standing in for the host processor
`timescale 1ns/1ps
module cpm_host_model (
	input  wire logic i_sda,    // sda wire
	input  wire logic i_scl,    // scl wire
	output logic      o_sda_oe, // pull sda low
	output logic      o_scl_oe  // pull scl low
);
	// ========
	// open drain bit engine; scl low and high above 4 link clocks
	localparam time T = 800;
	initial o_sda_oe = 1'b0;
	initial o_scl_oe = 1'b0;
	task automatic bit_io(input logic b, output logic r);
		int n;
		#400 o_sda_oe = !b;
		#T o_scl_oe = 1'b0;
		n = 0;
		// device may stretch scl on reads, so wait it out, bounded
		while (!i_scl && n < 100) begin
			#160 n++;
		end
		#T r = i_sda;
		o_scl_oe = 1'b1;
	endtask
	task automatic start();
		#400 o_sda_oe = 1'b0;
		#T o_scl_oe = 1'b0;
		#T o_sda_oe = 1'b1;
		#T o_scl_oe = 1'b1;
	endtask
	task automatic stop();
		#400 o_sda_oe = 1'b1;
		#T o_scl_oe = 1'b0;
		#T o_sda_oe = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(output logic [7:0] b, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(last, r);
	endtask
endmodule // cpm_host_model

// [sim/cpm_ctrl_port_test.sv]
// self-checking bench for the control port top
`timescale 1ns/1ps
module cpm_ctrl_port_test;
	logic       i_sys_clk = 1'b0;
	logic       i_link_clk = 1'b0;
	logic       i_rst = 1'b1;
	logic       a0, a1, h_sda, h_scl, d_sda, d_scl, k, rseen;
	logic       rp, an, dg, slp, i2c, spi;
	logic [7:0] live, ch, sl, c0, pg;
	logic [6:0] ad;
	logic [7:0] mem [5][128];
	logic [7:0] q[$];
	int         error_cnt = 0;
	int         compares = 0;
	wire        sda = !(h_sda | d_sda);
	wire        scl = !(h_scl | d_scl);
	always #10 i_sys_clk = !i_sys_clk;
	initial begin
		#37;
		forever #80 i_link_clk = !i_link_clk;
	end
	always @(posedge i_sys_clk) rseen <= i_rst ? 1'b0 : rseen | rp;
	cpm_ctrl_port #(.WAKE_CYCLES(20), .RAMP_CYCLES(8)) u_dut (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
		.i_data_or_select_pin(sda), .o_data_or_select_pin(),
		.o_data_or_select_pin_oe(d_sda), .i_scl_or_host_out_pin(scl),
		.o_scl_or_host_out_pin(), .o_scl_or_host_out_pin_oe(d_scl),
		.i_addr_bit0_or_serial_clock_pin(a0),
		.i_addr_bit1_or_host_in_pin(a1), .i_live_data(live),
		.o_input_channel_enables(ch), .o_output_slot_enables(sl),
		.o_ramp_down(rp), .o_analog_power_en(an), .o_digital_power_en(dg),
		.o_sleeping(slp), .o_soft_restore(), .o_i2c_selected(i2c),
		.o_spi_selected(spi));
	cpm_host_model u_host (.i_sda(sda), .i_scl(scl), .o_sda_oe(h_sda),
		.o_scl_oe(h_scl));
	// ========
	// checking and bus tasks
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic hdr(input logic [6:0] a, input logic [6:0] r);
		u_host.start();
		u_host.wbyte({a, 1'b0}, k);
		chk("addr ack", k, 1'b1);
		u_host.wbyte({1'b0, r}, k);
		chk("reg ack", k, 1'b1);
	endtask
	task automatic wr(input logic [6:0] a, input logic [6:0] r);
		hdr(a, r);
		foreach (q[i]) begin
			u_host.wbyte(q[i], k);
			chk("data ack", k, 1'b1);
			if (r == 7'h00)
				pg = q[i];
			else
				mem[pg][r] = q[i];
			r++;
		end
		u_host.stop();
	endtask
	task automatic rd(input logic [6:0] a, input logic [6:0] r, input int n);
		logic [7:0] v;
		hdr(a, r);
		u_host.start();
		u_host.wbyte({a, 1'b1}, k);
		chk("rd ack", k, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_host.rbyte(v, i == n - 1);
			chk("rd", v, r == 0 ? pg : pg == 1 ? live : mem[pg][r]);
			r++;
		end
		u_host.stop();
	endtask
	// ========
	// main sequence
	initial begin
		void'($urandom(32'h3E75E9BF));
		{a1, a0} = 2'($urandom_range(3, 1));
		live = 8'($urandom);
		pg = 8'h00;
		repeat (3) @(posedge i_sys_clk);
		#1 i_rst = 1'b0;
		ad = {5'h12, a1, a0};
		// sleep is left alone a while before the wake-up write
		repeat (40) @(posedge i_sys_clk);
		chk("reset sleep", slp, 1'b1);
		u_host.start();
		u_host.wbyte({ad ^ 7'h01, 1'b0}, k);
		u_host.stop();
		chk("foreign ack", k, 1'b0);
		chk("iface", {i2c, spi}, 2'b10);
		q = '{8'h01};
		wr(ad, 7'h02);
		// host keeps quiet while the wake-up sequence runs
		repeat (60) @(posedge i_sys_clk);
		chk("awake", slp, 1'b0);
		rd(ad, 7'h00, 1);
		q = '{8'h02};
		wr(ad, 7'h00);
		q = '{8'($urandom), 8'($urandom)};
		wr(ad, 7'h7E);
		rd(ad, 7'h7E, 2);
		q = '{8'h01};
		wr(ad, 7'h00);
		rd(ad, 7'h05, 1);
		q = '{8'h00};
		wr(ad, 7'h00);
		q = '{8'($urandom), 8'($urandom), 8'($urandom)};
		c0 = q[0];
		wr(ad, 7'h73);
		repeat (20) @(posedge i_sys_clk);
		chk("in ch", ch, q[0]);
		chk("slots", sl, q[1]);
		chk("power", {an, dg}, q[2][7:6]);
		rd(ad, 7'h73, 3);
		q = '{8'h05};
		wr(ad, 7'h02);
		rd(7'h48, 7'h73, 1);
		chk("no ramp", rseen, 1'b0);
		q = '{8'h04};
		wr(7'h48, 7'h02);
		repeat (30) @(posedge i_sys_clk);
		chk("ramped", rseen, 1'b1);
		chk("asleep", {slp, an, dg}, 3'b100);
		chk("kept", ch, c0);
		// only the exit write is sent in sleep, after a quiet spell
		repeat (200) @(posedge i_sys_clk);
		q = '{8'h05};
		wr(7'h48, 7'h02);
		repeat (60) @(posedge i_sys_clk);
		chk("rewake", slp, 1'b0);
		chk("rewake power", {an, dg}, mem[0][7'h75][7:6]);
		// restore from active mode, so the shutdown is visible
		q = '{8'h01};
		wr(7'h48, 7'h01);
		repeat (10) @(posedge i_sys_clk);
		chk("restored ch", ch, 8'h00);
		chk("restored sl", sl, 8'h00);
		chk("restore sleep", slp, 1'b1);
		chk("restore off", {an, dg}, 2'b00);
		complete_run();
	end
	initial begin
		#1800us;
		error_cnt++;
		complete_run();
	end
endmodule // cpm_ctrl_port_test
